//--- hdl/scl_station_ctrl.sv
// Station control: synthesizer frequency loader and discrete station lines
//
// Operation
// - Code is 14 R, 10 N, 7 A, control
// - Lower band loads one transmit word
// - Higher band shifts transmit then receive word
// - Lines idle at zero before load
// - Each data bit held forty microseconds
// - Strobe toggles twenty milliseconds then returns
// - Reload until lock detect reported
// - Load at reset and on lock loss
// - Outputs inverted at open collector pins
// - Lock polarity depends on band
// - Key line low whenever transmit needed
// - Mute on fast data, no carrier, no slow data
// - Tone mute high in voting absent clear voice
// - Remote key line low on remote key request
// - Route select high sends fast data
// - Modulation select low picks fast data
`timescale 1ns/10ps
`default_nettype none
module scl_station_ctrl
#(
  parameter int unsigned BIT_HOLD_CYC = scl_pkg::BIT_HOLD_CYC,
  parameter int unsigned STROBE_CYC   = scl_pkg::STROBE_CYC
)
(
  // Clock and reset
  input  wire logic          CLOCK,
  input  wire logic          RSTN,
  // Configuration
  input  wire logic          HIGH_BAND,
  input  wire logic [13:0]   TX_REF,
  input  wire logic [9:0]    TX_NDIV,
  input  wire logic [6:0]    TX_ADIV,
  input  wire logic          TX_CTRL,
  input  wire logic [13:0]   RX_REF,
  input  wire logic [9:0]    RX_NDIV,
  input  wire logic [6:0]    RX_ADIV,
  input  wire logic          RX_CTRL,
  // Synthesizer pins, open collector
  output logic               FREQ_LOAD_SERIAL_DATA,
  output logic               FREQ_LOAD_SHIFT_CLOCK,
  output logic               FREQ_LOAD_STROBE,
  input  wire logic          FREQ_LOCK_INDICATION,
  // Status of the loader
  output logic               LOAD_BUSY,
  output logic               SYNTH_LOCKED,
  // Station requests from the controller
  input  wire logic          TRANSMIT_KEY_REQUEST,
  input  wire logic          HSD_TX_ACTIVE,
  input  wire logic          LSD_PRESENT,
  input  wire logic          HSD_ROUTE_REQ,
  input  wire logic          CLEAR_VOICE_CALL,
  input  wire logic          VOTING_SYSTEM,
  input  wire logic          REMOTE_KEY_REQ,
  // Station discrete inputs
  input  wire logic          POWER_AMP_FAULT,
  input  wire logic          CARRIER_PRESENT_IN,
  input  wire logic          RX_SYNTH_LOCK_STATUS,
  input  wire logic          REMOTE_CALL_IN,
  // Station discrete outputs
  output logic               TRANSMIT_KEY_N,
  output logic               RECEIVER_AUDIO_MUTE_OUT_N,
  output logic               HSD_ROUTE_LSD_INHIBIT,
  output logic               MODULATION_PATH_SELECT,
  output logic               SQUELCH_TONE_MUTE,
  output logic               REMOTE_KEY_LINE_N,
  // Synchronized station status
  output logic               PA_FAULT,
  output logic               CARRIER_PRESENT,
  output logic               RX_SYNTH_FAULT,
  output logic               REMOTE_CALL
);
  typedef struct packed
  {
    scl_pkg::scl_state_t         state;
    logic [scl_pkg::CNT_W-1:0]   cnt;
    logic [5:0]                  bit_idx;
    logic                        data;
    logic                        sclk;
    logic                        strobe;
    logic                        locked;
    logic [4:0]                  sync1;
    logic [4:0]                  sync2;
    logic                        key;
    logic                        mute;
    logic                        route;
    logic                        modsel_n;
    logic                        tone_mute;
    logic                        rkey;
  } scl_top_state_t;

  scl_top_state_t st_r;
  scl_top_state_t st_nxt;
  scl_code_if     code ();
  logic           lock_ok;
  logic [5:0]     last_bit;

  // Clock pulse scaled to the hold parameter; fixed counts would miss a short hold
  localparam int unsigned RISE_CYC = BIT_HOLD_CYC / 4;
  localparam int unsigned FALL_CYC = (BIT_HOLD_CYC * 3) / 4;

  scl_code_build u_code
  (
    .clk     (CLOCK),
    .rst_n   (RSTN),
    .tx_ref  (TX_REF),
    .tx_ndiv (TX_NDIV),
    .tx_adiv (TX_ADIV),
    .tx_ctrl (TX_CTRL),
    .rx_ref  (RX_REF),
    .rx_ndiv (RX_NDIV),
    .rx_adiv (RX_ADIV),
    .rx_ctrl (RX_CTRL),
    .code    (code)
  );

  assign code.bit_index = st_r.bit_idx;

  // Band dependent lock sense after sync
  assign lock_ok = HIGH_BAND ? ~st_r.sync2[0] : st_r.sync2[0];

  assign last_bit = HIGH_BAND ? {1'b1, scl_pkg::BIT_LAST[4:0]} : scl_pkg::BIT_LAST;

  // Loader sequence and station line logic
  always_comb
  begin
    st_nxt = st_r;
    // Async pins pass two flops before use
    st_nxt.sync1 = {REMOTE_CALL_IN, RX_SYNTH_LOCK_STATUS, CARRIER_PRESENT_IN,
                    POWER_AMP_FAULT, FREQ_LOCK_INDICATION};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.cnt = st_r.cnt + 20'h00001;
    unique case (st_r.state)
      scl_pkg::SCL_IDLE:
      begin
        st_nxt.data    = 1'b0;
        st_nxt.sclk    = 1'b0;
        st_nxt.strobe  = 1'b0;
        st_nxt.bit_idx = 6'h00;
        st_nxt.cnt     = scl_pkg::CNT_ZERO;
        st_nxt.state   = scl_pkg::SCL_SHIFT;
      end
      scl_pkg::SCL_SHIFT:
      begin
        st_nxt.data = code.bit_value;
        if (st_r.cnt == 20'(RISE_CYC))
          st_nxt.sclk = 1'b1;
        if (st_r.cnt == 20'(FALL_CYC))
          st_nxt.sclk = 1'b0;
        if (st_r.cnt == 20'(BIT_HOLD_CYC - 1))
        begin
          st_nxt.cnt = scl_pkg::CNT_ZERO;
          if (st_r.bit_idx == last_bit)
          begin
            st_nxt.state  = scl_pkg::SCL_STROBE;
            st_nxt.strobe = ~st_r.strobe;
          end
          else
            st_nxt.bit_idx = st_r.bit_idx + 6'h01;
        end
      end
      scl_pkg::SCL_STROBE:
      begin
        if (st_r.cnt == 20'(STROBE_CYC - 1))
        begin
          st_nxt.strobe = ~st_r.strobe;
          st_nxt.state  = scl_pkg::SCL_CHECK;
        end
      end
      scl_pkg::SCL_CHECK:
      begin
        st_nxt.locked = lock_ok;
        st_nxt.state  = lock_ok ? scl_pkg::SCL_LOCKED : scl_pkg::SCL_IDLE;
      end
      scl_pkg::SCL_LOCKED:
      begin
        if (!lock_ok)
        begin
          st_nxt.locked = 1'b0;
          st_nxt.state  = scl_pkg::SCL_IDLE;
        end
      end
      default:
        st_nxt.state = scl_pkg::SCL_IDLE;
    endcase
    st_nxt.key = TRANSMIT_KEY_REQUEST | HSD_TX_ACTIVE;
    st_nxt.mute = HSD_TX_ACTIVE | ~st_r.sync2[2] | ~LSD_PRESENT;
    st_nxt.route = HSD_ROUTE_REQ;
    // Low selects filtered fast data
    // Held inverted so reset leaves the pin high, on the audio path like the route flop
    st_nxt.modsel_n = HSD_ROUTE_REQ;
    // Tone muted in voting without clear voice
    st_nxt.tone_mute = VOTING_SYSTEM & ~CLEAR_VOICE_CALL;
    st_nxt.rkey = REMOTE_KEY_REQ;
  end

  // Reset starts a load from idle
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // Pins carry complement of internal levels
  assign FREQ_LOAD_SERIAL_DATA = ~st_r.data;
  assign FREQ_LOAD_SHIFT_CLOCK = ~st_r.sclk;
  assign FREQ_LOAD_STROBE      = ~st_r.strobe;

  // Busy decoded from the state flops; lock status and discrete outputs straight from flops
  assign LOAD_BUSY                 = (st_r.state != scl_pkg::SCL_LOCKED);
  assign SYNTH_LOCKED              = st_r.locked;
  assign TRANSMIT_KEY_N            = ~st_r.key;
  assign RECEIVER_AUDIO_MUTE_OUT_N = ~st_r.mute;
  assign HSD_ROUTE_LSD_INHIBIT     = st_r.route;
  assign MODULATION_PATH_SELECT    = ~st_r.modsel_n;
  assign SQUELCH_TONE_MUTE         = st_r.tone_mute;
  assign REMOTE_KEY_LINE_N         = ~st_r.rkey;
  // Fault and remote call lines are active low at the pins; carrier present is active high
  assign PA_FAULT                  = ~st_r.sync2[1];
  assign CARRIER_PRESENT           = st_r.sync2[2];
  assign RX_SYNTH_FAULT            = ~st_r.sync2[3];
  assign REMOTE_CALL               = ~st_r.sync2[4];

  // Assertions
  // Named steps of a load, shared by the properties below
  sequence s_strobe_entry;
    $rose(st_r.state == scl_pkg::SCL_STROBE);
  endsequence
  sequence s_strobe_exit;
    $fell(st_r.state == scl_pkg::SCL_STROBE);
  endsequence
  sequence s_clock_rise;
    $rose(st_r.sclk);
  endsequence
  a_data_inverted: assert property (@(posedge CLOCK) disable iff (!RSTN)
    {FREQ_LOAD_SERIAL_DATA, FREQ_LOAD_SHIFT_CLOCK, FREQ_LOAD_STROBE}
      == ~{st_r.data, st_r.sclk, st_r.strobe}) else $error("pins not inverted");
  a_idle_clears: assert property (@(posedge CLOCK) disable iff (!RSTN)
    st_r.state == scl_pkg::SCL_IDLE |=> !st_r.sclk && !st_r.data && !st_r.strobe)
    else $error("lines not cleared");
  a_band_bits: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_strobe_entry |-> st_r.bit_idx == (HIGH_BAND ? 6'h3f : 6'h1f))
    else $error("strobe before last bit");
  a_strobe_toggle: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_strobe_entry |-> st_r.strobe != $past(st_r.strobe))
    else $error("strobe did not toggle");
  a_strobe_length: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_strobe_exit |-> $past(st_r.cnt) == 20'(STROBE_CYC - 1)
      && st_r.strobe != $past(st_r.strobe)) else $error("strobe length wrong");
  a_clock_mid_bit: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_clock_rise |-> st_r.state == scl_pkg::SCL_SHIFT && st_r.cnt == 20'(RISE_CYC + 1))
    else $error("shift clock rose out of place");
  a_data_steady: assert property (@(posedge CLOCK) disable iff (!RSTN)
    st_r.sclk && $past(st_r.sclk) |-> $stable(st_r.data))
    else $error("data moved under clock");
  // Bit index steps only at hold end
  a_bit_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
    st_r.state == scl_pkg::SCL_SHIFT && st_r.cnt != 20'(BIT_HOLD_CYC - 1)
    |=> $stable(st_r.bit_idx)) else $error("bit changed early");
  a_reload_unlock: assert property (@(posedge CLOCK) disable iff (!RSTN)
    st_r.state == scl_pkg::SCL_CHECK && !lock_ok |=> st_r.state == scl_pkg::SCL_IDLE)
    else $error("no reload when unlocked");
  a_lock_loss: assert property (@(posedge CLOCK) disable iff (!RSTN)
    st_r.state == scl_pkg::SCL_LOCKED && !lock_ok |=> st_r.state == scl_pkg::SCL_IDLE)
    else $error("no reload on lock loss");
  a_key_request: assert property (@(posedge CLOCK) disable iff (!RSTN)
    TRANSMIT_KEY_REQUEST |=> !TRANSMIT_KEY_N) else $error("key line not low");
  a_key_hsd: assert property (@(posedge CLOCK) disable iff (!RSTN)
    HSD_TX_ACTIVE |=> !TRANSMIT_KEY_N) else $error("key line not low on fast data");
  a_mute_hsd: assert property (@(posedge CLOCK) disable iff (!RSTN)
    HSD_TX_ACTIVE |=> !RECEIVER_AUDIO_MUTE_OUT_N) else $error("audio not muted");
  a_mute_carrier: assert property (@(posedge CLOCK) disable iff (!RSTN)
    !st_r.sync2[2] |=> !RECEIVER_AUDIO_MUTE_OUT_N) else $error("audio not muted on no carrier");
  a_route_mod: assert property (@(posedge CLOCK) disable iff (!RSTN)
    HSD_ROUTE_LSD_INHIBIT == !MODULATION_PATH_SELECT) else $error("route mismatch");
  a_route_follow: assert property (@(posedge CLOCK) disable iff (!RSTN)
    1'b1 |=> HSD_ROUTE_LSD_INHIBIT == $past(HSD_ROUTE_REQ)) else $error("route not following");
  a_tone_mute: assert property (@(posedge CLOCK) disable iff (!RSTN)
    VOTING_SYSTEM && !CLEAR_VOICE_CALL |=> SQUELCH_TONE_MUTE) else $error("tone not muted");
  a_remote_key: assert property (@(posedge CLOCK) disable iff (!RSTN)
    REMOTE_KEY_REQ |=> !REMOTE_KEY_LINE_N) else $error("remote key line not low");
endmodule
`default_nettype wire

//--- hdl/scl_pkg.sv
// Package of constants and types for the station control synthesizer loader
package scl_pkg;
  // Clock rate and bit timing
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned BIT_HOLD_US     = 40;
  localparam int unsigned STROBE_MS       = 20;
  localparam int unsigned BIT_HOLD_CYC    = BIT_HOLD_US * (CLK_HZ / 1000000);
  localparam int unsigned STROBE_CYC      = STROBE_MS * (CLK_HZ / 1000);
  // Clock pulse sits in the middle half of the bit period
  localparam int unsigned CLK_RISE_CYC    = BIT_HOLD_CYC / 4;
  localparam int unsigned CLK_FALL_CYC    = (BIT_HOLD_CYC * 3) / 4;
  // Frequency code layout, MSB first
  localparam int unsigned REF_W           = 14;
  localparam int unsigned NDIV_W          = 10;
  localparam int unsigned ADIV_W          = 7;
  localparam int unsigned CODE_W          = 32;
  localparam int unsigned REF_POS         = 18;
  localparam int unsigned NDIV_POS        = 8;
  localparam int unsigned ADIV_POS        = 1;
  localparam int unsigned CTRL_POS        = 0;
  localparam int unsigned CNT_W           = 20;
  localparam logic [5:0]  BIT_LAST        = 6'h1f;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 20'h00000;

  // Loader states, Gray codes along the usual path
  typedef enum logic [2:0]
  {
    SCL_IDLE   = 3'b000,
    SCL_SHIFT  = 3'b001,
    SCL_STROBE = 3'b011,
    SCL_CHECK  = 3'b010,
    SCL_LOCKED = 3'b110
  } scl_state_t;
endpackage

//--- hdl/scl_code_if.sv
// Interface carrying the frequency code words and serial bit selection
`timescale 1ns/10ps
`default_nettype none
interface scl_code_if;
  logic [31:0] code_word;
  logic [5:0]  bit_index;
  logic        bit_value;
  modport src (input bit_index, output code_word, output bit_value);
  modport dst (output bit_index, input code_word, input bit_value);
endinterface
`default_nettype wire

//--- hdl/scl_code_build.sv
// Frequency code builder and serial bit picker
`timescale 1ns/10ps
`default_nettype none
module scl_code_build
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Divider fields for the transmit and receive words
  input  wire logic [13:0]   tx_ref,
  input  wire logic [9:0]    tx_ndiv,
  input  wire logic [6:0]    tx_adiv,
  input  wire logic          tx_ctrl,
  input  wire logic [13:0]   rx_ref,
  input  wire logic [9:0]    rx_ndiv,
  input  wire logic [6:0]    rx_adiv,
  input  wire logic          rx_ctrl,
  // Link to the loader
  scl_code_if.src            code
);
  typedef struct packed
  {
    logic        bit_r;
  } scl_cb_state_t;

  scl_cb_state_t st_r;
  scl_cb_state_t st_nxt;
  logic [31:0]   tx_word;
  logic [31:0]   rx_word;

  assign tx_word = {tx_ref, tx_ndiv, tx_adiv, tx_ctrl};
  assign rx_word = {rx_ref, rx_ndiv, rx_adiv, rx_ctrl};
  assign code.code_word = code.bit_index[5] ? rx_word : tx_word;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.bit_r = code.code_word[5'h1f - code.bit_index[4:0]];
  end

  // Registered bit keeps the data line glitch free
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign code.bit_value = st_r.bit_r;
endmodule
`default_nettype wire

//--- tb/scl_synth_model.sv
// Behavioural synthesizer-exciter that captures the serial frequency words
`timescale 1ns/10ps
`default_nettype none
module scl_synth_model
(
  // Open-collector lines from the loader
  input  wire logic data_pin,
  input  wire logic shift_pin,
  input  wire logic strobe_pin,
  // Behaviour controls
  input  wire logic high_band,
  input  wire logic lock_ok,
  // Lock detect back to the loader
  output logic      lock_pin
);
  logic [63:0] sh        = 64'h0;
  logic [63:0] last_word = 64'h0;
  logic [7:0]  cnt       = 8'h00;
  logic [7:0]  last_cnt  = 8'h00;
  logic [7:0]  n_strobes = 8'h00;
  logic        lk        = 1'b0;
  time         t_prev    = 0;
  time         t_gap     = 0;
  time         t_sfall   = 0;
  time         t_strobe  = 0;

  // One bit per clock
  // Pin falls when the internal clock rises, so the bit is the inverse of the data pin
  always @(negedge shift_pin)
  begin
    sh = {sh[62:0], ~data_pin};
    cnt = cnt + 8'h01;
    lk = 1'b0;
    t_gap = $time - t_prev;
    t_prev = $time;
  end

  // Word is taken when the strobe starts; lock follows at once so the check cycle sees it
  always @(negedge strobe_pin)
  begin
    last_word = sh;
    last_cnt = cnt;
    cnt = 8'h00;
    lk = 1'b1;
    n_strobes = n_strobes + 8'h01;
    t_sfall = $time;
  end

  // Strobe length is measured for the bench
  always @(posedge strobe_pin)
  begin
    t_strobe = $time - t_sfall;
  end

  assign lock_pin = (lk & lock_ok) ^ high_band;
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the station control loader and discrete lines
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        CLOCK = 1'b0;
  logic        RSTN = 1'b0;
  logic        HIGH_BAND = 1'b0;
  logic        lock_ok = 1'b1;
  logic [31:0] txw = {14'h2a5b, 10'h2c3, 7'h55, 1'b1};
  logic [31:0] rxw = {14'h1234, 10'h1a7, 7'h2b, 1'b0};
  logic [10:0] ctl = 11'h10f;
  logic        sd, sc, ss, lock_pin, busy, locked;
  logic [9:0]  disc;
  int          mismatches = 0;
  int          n_checks = 0;
  int          i;
  logic [7:0]  base;
  logic [9:0]  dexp;
  // Request and station patterns, one per step of the discrete test
  logic [10:0] pats [7] = '{11'h10f, 11'h5a7, 11'h2f0, 11'h068, 11'h7ff, 11'h000, 11'h523};

  // Clock at 40 MHz
  always #12.5 CLOCK = ~CLOCK;

  // Short counts keep the run brief; expectations follow them
  scl_station_ctrl #(.BIT_HOLD_CYC(16), .STROBE_CYC(20)) uut
  (
    .CLOCK(CLOCK), .RSTN(RSTN), .HIGH_BAND(HIGH_BAND),
    .TX_REF(txw[31:18]), .TX_NDIV(txw[17:8]), .TX_ADIV(txw[7:1]), .TX_CTRL(txw[0]),
    .RX_REF(rxw[31:18]), .RX_NDIV(rxw[17:8]), .RX_ADIV(rxw[7:1]), .RX_CTRL(rxw[0]),
    .FREQ_LOAD_SERIAL_DATA(sd), .FREQ_LOAD_SHIFT_CLOCK(sc), .FREQ_LOAD_STROBE(ss),
    .FREQ_LOCK_INDICATION(lock_pin), .LOAD_BUSY(busy), .SYNTH_LOCKED(locked),
    .TRANSMIT_KEY_REQUEST(ctl[10]), .HSD_TX_ACTIVE(ctl[9]), .LSD_PRESENT(ctl[8]),
    .HSD_ROUTE_REQ(ctl[7]), .CLEAR_VOICE_CALL(ctl[6]), .VOTING_SYSTEM(ctl[5]),
    .REMOTE_KEY_REQ(ctl[4]), .POWER_AMP_FAULT(ctl[3]), .CARRIER_PRESENT_IN(ctl[2]),
    .RX_SYNTH_LOCK_STATUS(ctl[1]), .REMOTE_CALL_IN(ctl[0]),
    .TRANSMIT_KEY_N(disc[9]), .RECEIVER_AUDIO_MUTE_OUT_N(disc[8]),
    .HSD_ROUTE_LSD_INHIBIT(disc[7]), .MODULATION_PATH_SELECT(disc[6]),
    .SQUELCH_TONE_MUTE(disc[5]), .REMOTE_KEY_LINE_N(disc[4]), .PA_FAULT(disc[3]),
    .CARRIER_PRESENT(disc[2]), .RX_SYNTH_FAULT(disc[1]), .REMOTE_CALL(disc[0])
  );

  scl_synth_model m
  (
    .data_pin(sd), .shift_pin(sc), .strobe_pin(ss),
    .high_band(HIGH_BAND), .lock_ok(lock_ok), .lock_pin(lock_pin)
  );

  // Expected discrete outputs worked out from the station line meanings
  function automatic logic [9:0] disc_exp(input logic [10:0] c);
    disc_exp = {~(c[10] | c[9]), ~(c[9] | ~c[2] | ~c[8]), c[7], ~c[7], c[5] & ~c[6],
                ~c[4], ~c[3], c[2], ~c[1], ~c[0]};
  endfunction

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if ((mismatches == 0) && (n_checks > 0))
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Bounded wait for the loader to settle; a hang ends the run
  task automatic wait_lock(input string what);
    int k;
    k = 0;
    while ((busy !== 1'b0) && (k < 5000))
    begin
      @(posedge CLOCK);
      #1 k++;
    end
    if (k >= 5000)
    begin
      mismatches++;
      $display("BAD %s expected lock seen timeout", what);
      report_and_stop();
    end
  endtask

  initial
  begin
    repeat (6) @(posedge CLOCK);
    #1 check("pins in reset", {sd, sc, ss}, 3'b111);
    #1 RSTN = 1'b1;
    wait_lock("low band load");
    check("low band bits", m.last_cnt, 8'd32);
    check("tx word", m.last_word[31:0], txw);
    check("bit period ns", m.t_gap, 64'd400);
    check("strobe ns", m.t_strobe, 64'd500);
    check("locked", locked, 1'b1);
    // Data keeps the control bit after a load; clock and strobe are back at rest
    check("pins after load", {sd, sc, ss}, {~txw[0], 2'b11});
    $display("test low band done");
    // Discrete lines: each pattern settles through the pin synchronizers
    // Station levels held per pattern
    foreach (pats[j])
    begin
      @(posedge CLOCK);
      #2 ctl = pats[j];
      repeat (4) @(posedge CLOCK);
      #1 dexp = disc_exp(ctl);
      check("key and mute", disc[9:8], dexp[9:8]);
      check("route tone remote", disc[7:4], dexp[7:4]);
      check("station status", disc[3:0], dexp[3:0]);
    end
    $display("test discretes done");
    // Lock loss: two reloads must happen while the synthesizer refuses to lock
    base = m.n_strobes;
    @(posedge CLOCK);
    #2 lock_ok = 1'b0;
    i = 0;
    while ((m.n_strobes < base + 8'd2) && (i < 5000))
    begin
      @(posedge CLOCK);
      #1 i++;
    end
    check("reloads while unlocked", i < 5000, 1'b1);
    if (i >= 5000)
      report_and_stop();
    @(posedge CLOCK);
    #2 lock_ok = 1'b1;
    wait_lock("relock");
    check("relocked", locked, 1'b1);
    $display("test lock loss done");
    // High band after a fresh reset
    @(posedge CLOCK);
    #2 RSTN = 1'b0;
    HIGH_BAND = 1'b1;
    repeat (3) @(posedge CLOCK);
    #2 RSTN = 1'b1;
    wait_lock("high band load");
    check("high band bits", m.last_cnt, 8'd64);
    check("tx rx words", m.last_word, {txw, rxw});
    check("high band lock", locked, 1'b1);
    $display("test high band done");
    report_and_stop();
  end
endmodule
`default_nettype wire
